/* nmf_frontend.sv */
// Level detector, oscillator and mixer, matched filters and decimator.
`timescale 1ns/1ps
module nmf_frontend
  import nmf_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [IN_W-1:0]   i_in,
  input  wire logic [IN_W-1:0]   q_in,
  input  wire logic              sample_en_n,
  input  wire logic [31:0]       loop_lead,
  input  wire logic [31:0]       loop_lag,
  input  wire logic              loop_valid,
  output logic                   level_compare_out,
  output logic [31:0]            ext_nco_word,
  output logic                   ext_nco_valid,
  output logic [DW-1:0]          mf_i,
  output logic [DW-1:0]          mf_q,
  output logic                   mf_valid,
  output logic [DW-1:0]          sym_end_i,
  output logic [DW-1:0]          sym_end_q,
  output logic [DW-1:0]          sym_mid_i,
  output logic [DW-1:0]          sym_mid_q,
  output logic                   sym_valid
);
  logic [31:0] datapath_reg, carrier1_reg, upper_reg, lower_reg;
  logic [31:0] carrier_phase_increment_reg, phase_acc_reg;
  logic [31:0] rd_next;
  logic        wr_en, rd_en, hit;

  // Registers answer with one wait state so read data comes from a flop.
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      OFS_DATAPATH:  rd_next = datapath_reg;
      OFS_CARRIER1:  rd_next = carrier1_reg;
      OFS_UPPER_LIM: rd_next = upper_reg;
      OFS_LOWER_LIM: rd_next = lower_reg;
      OFS_PHASE_INC: rd_next = carrier_phase_increment_reg;
      OFS_STATUS:    rd_next = {31'h0, level_compare_out};
      OFS_EXT_NCO:   rd_next = ext_nco_word;
      default: begin
        rd_next = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_en;
      pslverr <= rd_en & ~pwrite & ~hit;
      if (rd_en) begin
        prdata <= pwrite ? 32'h0 : rd_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      datapath_reg <= RST_DATAPATH;
      carrier1_reg <= RST_CARRIER1;
      upper_reg    <= RST_LIMIT;
      lower_reg    <= RST_LIMIT;
    end else if (wr_en) begin
      case (paddr)
        OFS_DATAPATH:  datapath_reg <= pwdata;
        OFS_CARRIER1:  carrier1_reg <= pwdata;
        OFS_UPPER_LIM: upper_reg <= pwdata;
        OFS_LOWER_LIM: lower_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // Carrier loop routing and phase increment.
  logic [32:0] lim_sum;
  logic [31:0] centre;
  assign lim_sum = {upper_reg[31], upper_reg} + {lower_reg[31], lower_reg};
  assign centre  = lim_sum[32:1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_phase_increment_reg <= RST_PHASE_INC;
      ext_nco_word  <= 32'h0;
      ext_nco_valid <= 1'b0;
    end else begin
      ext_nco_valid <= 1'b0;
      if (loop_valid) begin
        if (carrier1_reg[CL_ROUTE_EXT]) begin
          ext_nco_word  <= loop_lead + loop_lag;
          ext_nco_valid <= 1'b1;
        end else if (carrier1_reg[CL_LEADLAG]) begin
          carrier_phase_increment_reg <= loop_lead;
          ext_nco_word  <= loop_lag;
          ext_nco_valid <= 1'b1;
        end else begin
          carrier_phase_increment_reg <= centre + loop_lead + loop_lag;
        end
      end else if (wr_en && paddr == OFS_PHASE_INC) begin
        carrier_phase_increment_reg <= pwdata;
      end
    end
  end

  // Wrapping 32-bit sum: one sweep is one turn, a negative step turns back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_acc_reg <= 32'h0;
    end else begin
      phase_acc_reg <= phase_acc_reg + carrier_phase_increment_reg;
    end
  end

  logic [TRIG_W-1:0] cos_w, sin_w;
  nmf_trig u_trig (
    .pclk    (pclk),
    .presetn (presetn),
    .phase   (phase_acc_reg[31:26]),
    .cos_reg (cos_w),
    .sin_reg (sin_w)
  );

  // Sample pin inputs i_in, q_in and sample_en_n pass two flops before any logic looks at them.
  logic [IN_W-1:0] i_s1, i_s2, q_s1, q_s2;
  logic            en_s1, en_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_s1  <= 10'h000;
      i_s2  <= 10'h000;
      q_s1  <= 10'h000;
      q_s2  <= 10'h000;
      en_s1 <= 1'b1;
      en_s2 <= 1'b1;
    end else begin
      i_s1  <= i_in;
      i_s2  <= i_s1;
      q_s1  <= q_in;
      q_s2  <= q_s1;
      en_s1 <= sample_en_n;
      en_s2 <= en_s1;
    end
  end

  // Offset binary becomes two's complement by flipping the sign bit.
  logic [IN_W-1:0] a_i, a_q;
  logic            a_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_i <= 10'h000;
      a_q <= 10'h000;
      a_v <= 1'b0;
    end else begin
      a_v <= ~en_s2;
      if (!en_s2) begin
        a_i <= i_s2 ^ {datapath_reg[DP_FORMAT], 9'h000};
        a_q <= q_s2 ^ {datapath_reg[DP_FORMAT], 9'h000};
      end
    end
  end

  // Magnitude is max plus half of min; cheap, and at most about 12 percent high.
  function automatic logic [IN_W-1:0] absv(input logic [IN_W-1:0] x);
    absv = x[IN_W-1] ? 10'h000 - x : x;
  endfunction : absv

  logic [IN_W-1:0] ai_abs, aq_abs, mx, mn;
  logic [IN_W:0]   mag;
  logic            above;
  assign ai_abs = absv(a_i);
  assign aq_abs = absv(a_q);
  assign mx     = (ai_abs > aq_abs) ? ai_abs : aq_abs;
  assign mn     = (ai_abs > aq_abs) ? aq_abs : ai_abs;
  assign mag    = {1'b0, mx} + {2'b00, mn[IN_W-1:1]};
  assign above  = mag[IN_W:IN_W-7] > datapath_reg[DP_THR_LO+:8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_compare_out <= 1'b0;
    end else if (a_v) begin
      level_compare_out <= above ^ datapath_reg[DP_POLARITY];
    end
  end

  // Complex mixer.
  logic signed [17:0] p_ic, p_qs, p_is, p_qc;
  logic signed [18:0] m_i, m_q;
  nmf_iq_t mix_reg;
  assign p_ic = $signed(a_i) * $signed(cos_w);
  assign p_qs = $signed(a_q) * $signed(sin_w);
  assign p_is = $signed(a_i) * $signed(sin_w);
  assign p_qc = $signed(a_q) * $signed(cos_w);
  assign m_i  = 19'(p_ic) - 19'(p_qs);
  assign m_q  = 19'(p_is) + 19'(p_qc);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_reg <= '0;
    end else begin
      mix_reg.v <= a_v;
      if (datapath_reg[DP_NCO_BYP]) begin
        mix_reg.i <= {a_i, 2'b00};
        mix_reg.q <= {a_q, 2'b00};
      end else begin
        mix_reg.i <= m_i[17:6];
        mix_reg.q <= m_q[17:6];
      end
    end
  end

  // Shaped pulse filter; taps shift only on enabled samples.
  function automatic logic signed [8:0] coef(input int k);
    int j;
    j = (k > 7) ? 14 - k : k;
    case (j)
      0: coef = 9'sd2;
      1: coef = -9'sd2;
      2: coef = 9'sd1;
      3: coef = 9'sd8;
      4: coef = -9'sd16;
      5: coef = -9'sd14;
      6: coef = 9'sd86;
      default: coef = 9'sd160;
    endcase
  endfunction : coef

  logic [DW-1:0] tap_i [TAPS];
  logic [DW-1:0] tap_q [TAPS];
  logic signed [RRC_W-1:0] acc_i, acc_q;
  nmf_iq_t rrc_reg;

  always_comb begin
    acc_i = '0;
    acc_q = '0;
    for (int k = 0; k < TAPS; k++) begin
      acc_i = acc_i + RRC_W'($signed(tap_i[k]) * coef(k));
      acc_q = acc_q + RRC_W'($signed(tap_q[k]) * coef(k));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < TAPS; k++) begin
        tap_i[k] <= '0;
        tap_q[k] <= '0;
      end
    end else if (mix_reg.v) begin
      tap_i[0] <= mix_reg.i;
      tap_q[0] <= mix_reg.q;
      for (int k = 1; k < TAPS; k++) begin
        tap_i[k] <= tap_i[k-1];
        tap_q[k] <= tap_q[k-1];
      end
    end
  end

  // The sum of products is read one clock after the taps moved.
  logic rrc_ready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rrc_ready <= 1'b0;
    end else begin
      rrc_ready <= mix_reg.v;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rrc_reg <= '0;
    end else begin
      rrc_reg.v <= rrc_ready;
      if (rrc_ready) begin
        rrc_reg.i <= acc_i[19:8];
        rrc_reg.q <= acc_q[19:8];
      end
    end
  end

  // Arrangement select and integrate-and-dump decimator.
  nmf_mode_t mode;
  logic [2:0] dec;
  nmf_iq_t    id_in;
  logic       id_on;
  assign mode  = nmf_mode_t'(datapath_reg[DP_MODE_LO+:2]);
  assign dec   = (datapath_reg[DP_DEC_LO+:3] > DEC_MAX) ? DEC_MAX
                 : datapath_reg[DP_DEC_LO+:3];
  assign id_in = (mode == NMF_MF_BOTH || mode == NMF_MF_RRC) ? rrc_reg
                 : mix_reg;
  assign id_on = (mode == NMF_MF_BOTH || mode == NMF_MF_ID) && dec != 3'h0;

  logic [3:0] cnt_reg, len_m1;
  logic [2:0] sh;
  logic [ACC_W-1:0] ai_reg, aq_reg, pi_reg, pq_reg, di, dq, si, sq;
  logic [ACC_W:0]   sum_i, sum_q;
  assign len_m1 = 4'((5'h01 << (dec - 3'h1)) - 5'h01);
  assign sh     = datapath_reg[DP_SHIFT_EN] ? dec - 3'h1 : 3'h0;
  assign di     = ai_reg + ACC_W'($signed(id_in.i));
  assign dq     = aq_reg + ACC_W'($signed(id_in.q));
  assign si     = ACC_W'($signed(di) >>> sh);
  assign sq     = ACC_W'($signed(dq) >>> sh);
  assign sum_i  = {si[ACC_W-1], si} + {pi_reg[ACC_W-1], pi_reg};
  assign sum_q  = {sq[ACC_W-1], sq} + {pq_reg[ACC_W-1], pq_reg};

  nmf_iq_t id_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      ai_reg  <= '0;
      aq_reg  <= '0;
      pi_reg  <= '0;
      pq_reg  <= '0;
      id_out  <= '0;
    end else begin
      id_out.v <= 1'b0;
      if (!id_on) begin
        id_out  <= id_in;
        cnt_reg <= 4'h0;
        ai_reg  <= '0;
        aq_reg  <= '0;
      end else if (id_in.v) begin
        if (cnt_reg >= len_m1) begin
          cnt_reg  <= 4'h0;
          ai_reg   <= '0;
          aq_reg   <= '0;
          pi_reg   <= si;
          pq_reg   <= sq;
          id_out.v <= 1'b1;
          id_out.i <= sum_i[12:1];
          id_out.q <= sum_q[12:1];
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
          ai_reg  <= di;
          aq_reg  <= dq;
        end
      end
    end
  end

  // Two samples per symbol: alternate samples are mid and end of symbol.
  logic end_phase_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_phase_reg <= 1'b0;
      mf_i      <= '0;
      mf_q      <= '0;
      mf_valid  <= 1'b0;
      sym_end_i <= '0;
      sym_end_q <= '0;
      sym_mid_i <= '0;
      sym_mid_q <= '0;
      sym_valid <= 1'b0;
    end else begin
      mf_valid  <= id_out.v;
      sym_valid <= id_out.v & end_phase_reg;
      if (id_out.v) begin
        mf_i          <= id_out.i;
        mf_q          <= id_out.q;
        end_phase_reg <= ~end_phase_reg;
        if (end_phase_reg) begin
          sym_end_i <= id_out.i;
          sym_end_q <= id_out.q;
        end else begin
          sym_mid_i <= id_out.i;
          sym_mid_q <= id_out.q;
        end
      end
    end
  end
endmodule : nmf_frontend

/* nmf_pkg.sv */
// Package with register map, field positions and types of the demodulator front end.
package nmf_pkg;
  localparam logic [7:0]  OFS_DATAPATH   = 8'h00;
  localparam logic [7:0]  OFS_CARRIER1   = 8'h04;
  localparam logic [7:0]  OFS_UPPER_LIM  = 8'h08;
  localparam logic [7:0]  OFS_LOWER_LIM  = 8'h0c;
  localparam logic [7:0]  OFS_PHASE_INC  = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam logic [7:0]  OFS_EXT_NCO    = 8'h18;

  localparam int DP_MODE_LO   = 1;
  localparam int DP_DEC_LO    = 3;
  localparam int DP_SHIFT_EN  = 6;
  localparam int DP_NCO_BYP   = 10;
  localparam int DP_POLARITY  = 13;
  localparam int DP_FORMAT    = 15;
  localparam int DP_THR_LO    = 16;
  localparam int CL_LEADLAG   = 5;
  localparam int CL_ROUTE_EXT = 6;

  localparam logic [31:0] RST_DATAPATH  = 32'h0000_0000;
  localparam logic [31:0] RST_CARRIER1  = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT     = 32'h0000_0000;
  localparam logic [31:0] RST_PHASE_INC = 32'h0000_0000;

  localparam int IN_W   = 10;
  localparam int DW     = 12;
  localparam int TRIG_W = 8;
  localparam int TAPS   = 15;
  localparam int RRC_W  = 22;
  localparam int ACC_W  = 16;
  localparam logic [2:0] DEC_MAX = 3'h5;

  typedef enum logic [1:0] {
    NMF_MF_NONE = 2'b00,
    NMF_MF_RRC  = 2'b01,
    NMF_MF_ID   = 2'b10,
    NMF_MF_BOTH = 2'b11
  } nmf_mode_t;

  typedef struct packed {
    logic          v;
    logic [DW-1:0] i;
    logic [DW-1:0] q;
  } nmf_iq_t;
endpackage : nmf_pkg

/* nmf_trig.sv */
// Quadrature sine and cosine lookup driven by the top phase bits.
`timescale 1ns/1ps
module nmf_trig
  import nmf_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [5:0]        phase,
  output logic      [TRIG_W-1:0] cos_reg,
  output logic      [TRIG_W-1:0] sin_reg
);
  // Quarter-wave table; the other three quadrants come from symmetry.
  function automatic logic [7:0] quarter(input logic [4:0] k);
    case (k)
      5'h00: quarter = 8'h00;
      5'h01: quarter = 8'h0c;
      5'h02: quarter = 8'h19;
      5'h03: quarter = 8'h25;
      5'h04: quarter = 8'h31;
      5'h05: quarter = 8'h3c;
      5'h06: quarter = 8'h47;
      5'h07: quarter = 8'h51;
      5'h08: quarter = 8'h5a;
      5'h09: quarter = 8'h62;
      5'h0a: quarter = 8'h6a;
      5'h0b: quarter = 8'h70;
      5'h0c: quarter = 8'h75;
      5'h0d: quarter = 8'h7a;
      5'h0e: quarter = 8'h7d;
      5'h0f: quarter = 8'h7e;
      default: quarter = 8'h7f;
    endcase
  endfunction : quarter

  function automatic logic [7:0] sine(input logic [5:0] p);
    logic [7:0] m;
    m = p[4] ? quarter(5'h10 - {1'b0, p[3:0]}) : quarter({1'b0, p[3:0]});
    sine = p[5] ? 8'h00 - m : m;
  endfunction : sine

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cos_reg <= 8'h00;
      sin_reg <= 8'h00;
    end else begin
      sin_reg <= sine(phase);
      cos_reg <= sine(phase + 6'h10);
    end
  end
endmodule : nmf_trig

/* nmf_monitor.sv */
// Checker of the front end port behaviour, bound to the top module.
`timescale 1ns/1ps
module nmf_monitor
  import nmf_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          sample_en_n,
  input wire logic          loop_valid,
  input wire logic          level_compare_out,
  input wire logic [31:0]   ext_nco_word,
  input wire logic          ext_nco_valid,
  input wire logic [DW-1:0] mf_i,
  input wire logic          mf_valid,
  input wire logic [DW-1:0] sym_end_i,
  input wire logic          sym_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_READY_WAIT: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("Answer not after one wait state.");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("Ready held longer than one cycle.");
  AST_ERR_READ: assert property (pslverr |-> pready && psel && !pwrite
    && prdata == 32'h0) else $error("Bad refused read answer.");
  // Polarity writes must not move the pin, only accepted samples may.
  AST_LEVEL_CAUSE: assert property ($changed(level_compare_out)
    |-> !$past(sample_en_n, 4) || !$past(sample_en_n, 5))
    else $error("Level output moved without a sample.");
  AST_MF_HOLD: assert property ($changed(mf_i) |-> mf_valid)
    else $error("Filter output moved without valid.");
  AST_SYM_HOLD: assert property ($changed(sym_end_i) |-> sym_valid)
    else $error("Symbol output moved without valid.");
  AST_SYM_SPACING: assert property (sym_valid |=> !sym_valid)
    else $error("End samples on consecutive cycles.");
  AST_EXT_CAUSE: assert property (ext_nco_valid |-> $past(loop_valid))
    else $error("External word valid without loop terms.");
  AST_EXT_HOLD: assert property ($changed(ext_nco_word)
    |-> ext_nco_valid) else $error("External word moved without valid.");
endmodule : nmf_monitor

bind nmf_frontend nmf_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .sample_en_n, .loop_valid, .level_compare_out, .ext_nco_word,
  .ext_nco_valid, .mf_i, .mf_valid, .sym_end_i, .sym_valid
);

/* nmf_src.sv */
// Model of the upstream sample source feeding the parallel inputs.
`timescale 1ns/1ps
module nmf_src
  import nmf_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            go,
  input  wire logic [IN_W-1:0] smp_i,
  input  wire logic [IN_W-1:0] smp_q,
  output logic      [IN_W-1:0] i_in,
  output logic      [IN_W-1:0] q_in,
  output logic                 sample_en_n
);
  initial begin
    i_in        = '0;
    q_in        = '0;
    sample_en_n = 1'b1;
  end
  // Words toggle between samples so a stale value can never pass as data.
  always @(posedge pclk) begin
    sample_en_n <= ~go;
    i_in        <= go ? smp_i : ~i_in;
    q_in        <= go ? smp_q : ~q_in;
  end
endmodule : nmf_src

/* tb.sv */
// Testbench of the demodulator front end.
`timescale 1ns/1ps
module tb
  import nmf_pkg::*;
;
  logic              pclk       = 1'b0;
  logic              presetn    = 1'b0;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [7:0]        paddr      = 8'h00;
  logic [31:0]       pwdata     = 32'h0;
  logic [31:0]       loop_lead  = 32'h0;
  logic [31:0]       loop_lag   = 32'h0;
  logic              loop_valid = 1'b0;
  logic              go         = 1'b0;
  logic [IN_W-1:0]   smp_i      = '0;
  logic [IN_W-1:0]   smp_q      = '0;
  logic [31:0]       prdata, ext_nco_word, rdat, cfg;
  logic              pready, pslverr, rerr, hi, h0, qnz;
  logic [IN_W-1:0]   i_in, q_in;
  logic              sample_en_n, level_compare_out, ext_nco_valid;
  logic [DW-1:0]     mf_i, mf_q, sym_end_i;
  logic              mf_valid, sym_valid;
  logic [DW-1:0]     mfq[$];
  int                error_cnt, checks, cyc, symc, n, extc;
  logic [7:0]        regs [5] = '{OFS_DATAPATH, OFS_CARRIER1, OFS_UPPER_LIM,
                                  OFS_LOWER_LIM, OFS_PHASE_INC};
  logic [31:0]       wv [5]   = '{32'h00c3_a44a, 32'h60, 32'h8765_4321,
                                  32'h1234_5678, 32'hfedc_ba98};
  logic [31:0]       inc_x [3] = '{32'h3c, 32'hffff_ffec, 32'hffff_ffec};
  logic [31:0]       ext_x [3] = '{32'h0, 32'h5, 32'hffff_fff1};

  nmf_src src (.pclk, .go, .smp_i, .smp_q, .i_in, .q_in, .sample_en_n);
  nmf_frontend uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_in, .q_in, .sample_en_n, .loop_lead, .loop_lag,
    .loop_valid, .level_compare_out, .ext_nco_word, .ext_nco_valid, .mf_i,
    .mf_q, .mf_valid, .sym_end_i, .sym_end_q(), .sym_mid_i(), .sym_mid_q(),
    .sym_valid
  );

  always #25 pclk = ~pclk;

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hold(input int c);
    repeat (c) @(posedge pclk);
  endtask : hold

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    hold(8);
    presetn <= 1'b1;
  endtask : rst

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic smp(input logic [IN_W-1:0] i, input logic [IN_W-1:0] q,
                     input int c);
    repeat (c) begin
      @(posedge pclk);
      go    <= 1'b1;
      smp_i <= i;
      smp_q <= q;
    end
    @(posedge pclk);
    go <= 1'b0;
  endtask : smp

  // Collected here so that every output pulse is seen, however close.
  always @(posedge pclk) begin
    cyc++;
    if (!presetn) begin
      mfq.delete();
      symc = 0;
      extc = 0;
      qnz  = 1'b0;
    end else begin
      if (ext_nco_valid === 1'b1) extc++;
      if (mf_valid === 1'b1) begin
        mfq.push_back(mf_i);
        qnz = qnz | (|mf_q);
      end
      if (sym_valid === 1'b1) symc++;
    end
    if (cyc == 40000) begin
      error_cnt++;
      $display("ERROR at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  initial begin
    rst();
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, regs[k], 32'h0);
      chk(rdat, 32'h0);
      apb(1'b1, regs[k], wv[k]);
      apb(1'b0, regs[k], 32'h0);
      chk(rdat, wv[k]);
      chk(rerr, 1'b0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk(rdat, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    chk(rerr, 1'b0);
    rst();
    for (int p = 0; p < 2; p++) begin
      cfg = 32'h0020_0000 | (32'(p) << DP_POLARITY);
      apb(1'b1, OFS_DATAPATH, cfg);
      smp(10'h12c, 10'h000, 1);
      hold(8);
      hi = level_compare_out;
      chk(hi === 1'b0 || hi === 1'b1, 1'b1);
      smp(10'h2d4, 10'h000, 1);
      hold(8);
      chk(level_compare_out, hi);
      smp(10'h014, 10'h000, 1);
      hold(8);
      chk(level_compare_out, !hi);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdat[0], level_compare_out);
      apb(1'b1, OFS_DATAPATH, cfg | (32'h1 << DP_FORMAT));
      smp(10'h32c, 10'h200, 1);
      hold(8);
      chk(level_compare_out, hi);
      if (p == 0) h0 = hi;
      else chk(hi, !h0);
    end
    rst();
    apb(1'b1, OFS_DATAPATH, 32'(NMF_MF_RRC) << DP_MODE_LO);
    smp(10'h1ff, 10'h000, 1);
    smp(10'h000, 10'h000, 20);
    hold(12);
    chk(mfq.size() >= 15, 1'b1);
    for (int k = 0; k < 7; k++) chk(mfq[k], mfq[14-k]);
    chk($signed(mfq[7]) > $signed(mfq[6]) && $signed(mfq[6]) > 0, 1);
    chk($signed(mfq[4]) < 0 && $signed(mfq[5]) < 0 && $signed(mfq[3]) > 0,
        1'b1);
    chk(qnz, 1'b0);
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 6; d++) begin
        rst();
        apb(1'b1, OFS_DATAPATH, 32'((m << DP_MODE_LO) | (d << DP_DEC_LO) |
            (1 << DP_NCO_BYP) | (1 << DP_SHIFT_EN)));
        smp(10'h064, 10'h000, 32);
        hold(16);
        n = (m < 2 || d == 0) ? 32 : 32 >> (d - 1);
        chk(mfq.size(), n);
        if (m >= 2 && d > 0) chk(symc, n / 2);
        if (m % 2 == 0) chk(mf_i, 12'h190);
        if (m == 2 && d > 0) chk(sym_end_i, 12'h190);
      end
    end
    rst();
    apb(1'b1, OFS_UPPER_LIM, 32'h64);
    apb(1'b1, OFS_LOWER_LIM, 32'h32);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, OFS_CARRIER1, 32'(c) << CL_LEADLAG);
      @(posedge pclk);
      loop_valid <= 1'b1;
      loop_lead  <= 32'hffff_ffec;
      loop_lag   <= 32'h5;
      @(posedge pclk);
      loop_valid <= 1'b0;
      hold(3);
      apb(1'b0, OFS_PHASE_INC, 32'h0);
      chk(rdat, inc_x[c]);
      if (c > 0) chk(ext_nco_word, ext_x[c]);
    end
    chk(extc, 2);
    // Equal limits with zero loop terms must pin the increment to the limit.
    apb(1'b1, OFS_UPPER_LIM, 32'h40);
    apb(1'b1, OFS_LOWER_LIM, 32'h40);
    apb(1'b1, OFS_CARRIER1, 32'h0);
    @(posedge pclk);
    loop_valid <= 1'b1;
    loop_lead  <= 32'h0;
    loop_lag   <= 32'h0;
    @(posedge pclk);
    loop_valid <= 1'b0;
    hold(3);
    apb(1'b0, OFS_PHASE_INC, 32'h0);
    chk(rdat, 32'h40);
    end_of_test();
  end
endmodule : tb
